// file: rtl/sbcb_channel.sv
`timescale 1ns/1ns
`default_nettype none
`include "sbcb_regs.svh"

module sbcb_channel #(
	parameter int RAM_BYTES = 16384
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Register port.
	input wire sbcb_pkg::sbcb_reg_req_t reg_req,
	output logic [31:0] reg_rdata,
	// Serial link pins.
	input wire logic link_clk,
	input wire logic link_frame,
	input wire logic link_data,
	input wire logic far_end_abort,
	input wire logic far_end_protocol_fault,
	// System memory write master.
	output var sbcb_pkg::sbcb_mem_t mem,
	input wire logic mem_ack,
	// Interrupt.
	output logic irq
);

	localparam int AW = $clog2(RAM_BYTES);
	localparam int PAD = 16 - AW;

	if (RAM_BYTES < 16 || RAM_BYTES > 32768 || (1 << AW) != RAM_BYTES) begin : g_chk
		$error("RAM_BYTES must be a power of two from 16 to 32768");
	end

	// ****************************************
	// State
	// ****************************************
	logic ctrl_en;
	logic byte_order_sel;
	logic active_page_sel;
	logic [AW-1:0] base_offset;
	logic [AW-1:0] buffer_depth;
	logic [AW-1:0] rd_offset;
	logic [AW-1:0] wr_offset;
	logic [7:0] rd_packet_count;
	logic [7:0] wr_packet_count;
	logic [4:0] rd_state;
	logic [4:0] wr_state;
	sbcb_pkg::sbcb_page_t [1:0] page;
	logic [31:0] page_rd [2];
	logic cur_page;
	logic [3:0] irq_sts;
	logic [3:0] irq_en;
	logic [7:0] dual_port_buffer_ram [RAM_BYTES];
	logic [7:0] ram_q;
	sbcb_pkg::sbcb_rd_t rd_fsm;
	logic [31:0] wbuf;
	logic [3:0] wbe;
	logic [11:0] page_cnt;
	logic pend_end;
	logic [4:0] ls;
	logic lclk_q;
	logic [7:0] lk_sh;
	logic [2:0] lk_bits;
	logic lk_v;
	logic [7:0] lk_byte;
	logic [1:0] wr_paddr;
	logic [1:0] wr_pctl;

	// ****************************************
	// Register decode
	// ****************************************
	wire [7:0] ra = reg_req.addr;
	wire [31:0] wd = reg_req.wdata;
	wire wr_ctrl = reg_req.wr && ra == `SBCB_A_CTRL;
	wire wr_bcfg = reg_req.wr && ra == `SBCB_A_BCFG;
	wire wr_bptr = reg_req.wr && ra == `SBCB_A_BPTR;
	wire wr_bsts = reg_req.wr && ra == `SBCB_A_BSTS;
	wire wr_iclr = reg_req.wr && ra == `SBCB_A_ICLR;
	wire wr_ien = reg_req.wr && ra == `SBCB_A_IEN;

	// ****************************************
	// Link sampling
	// ****************************************
	sbcb_sync #(
		.W(5)
	) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.d({link_clk, link_frame, link_data, far_end_abort, far_end_protocol_fault}),
		.q(ls)
	);

	wire ls_clk = ls[4];
	wire ls_frame = ls[3];
	wire ls_data = ls[2];
	wire ls_brk = ls[1];
	wire ls_perr = ls[0];

	// Bits are taken on the rising link clock edge, MSB first; a frame gap realigns the byte.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lclk_q <= 1'b0;
			lk_sh <= 8'h00;
			lk_bits <= 3'd0;
			lk_v <= 1'b0;
			lk_byte <= 8'h00;
		end else begin
			lclk_q <= ls_clk;
			lk_v <= 1'b0;
			if (!ls_frame) begin
				lk_bits <= 3'd0;
			end else if (ls_clk && !lclk_q) begin
				lk_sh <= {lk_sh[6:0], ls_data};
				lk_bits <= lk_bits + 3'd1;
				if (lk_bits == 3'd7) begin
					lk_v <= 1'b1;
					lk_byte <= {lk_sh[6:0], ls_data};
				end
			end
		end
	end

	// ****************************************
	// Channel buffer
	// ****************************************
	wire ptr_eq = rd_offset == wr_offset;
	wire cnt_eq = rd_packet_count == wr_packet_count;
	wire buf_empty = ptr_eq && cnt_eq;
	wire buf_full = ptr_eq && !cnt_eq;
	wire ram_we = lk_v && ctrl_en && !buf_full;
	wire wr_ovf = lk_v && ctrl_en && buf_full;
	wire [AW-1:0] ram_waddr = base_offset + wr_offset;
	wire [AW-1:0] ram_raddr = base_offset + rd_offset;
	wire [AW-1:0] next_wr_offset = (wr_offset == buffer_depth) ? '0 : wr_offset + 1'b1;
	wire [AW-1:0] next_rd_offset = (rd_offset == buffer_depth) ? '0 : rd_offset + 1'b1;
	wire rd_load = rd_fsm == sbcb_pkg::RD_LOAD;
	wire wr_pkt_end;
	wire rd_pkt_end;
	wire rd_pkt_start;

	// Storage has no reset; the offsets and counts guard every byte that is read.
	always_ff @(posedge clk) begin
		if (ram_we) begin
			dual_port_buffer_ram[ram_waddr] <= lk_byte;
		end
		ram_q <= dual_port_buffer_ram[ram_raddr];
	end

	sbcb_len_track u_wr_len (
		.clk(clk),
		.rst_n(rst_n),
		.clr(!ctrl_en),
		.valid(ram_we),
		.data(lk_byte),
		.pkt_start(),
		.pkt_end(wr_pkt_end)
	);

	sbcb_len_track u_rd_len (
		.clk(clk),
		.rst_n(rst_n),
		.clr(!ctrl_en),
		.valid(rd_load),
		.data(ram_q),
		.pkt_start(rd_pkt_start),
		.pkt_end(rd_pkt_end)
	);

	// ****************************************
	// Memory side
	// ****************************************
	wire cur_ready = page[cur_page].ready;
	wire rd_go = rd_fsm == sbcb_pkg::RD_IDLE && ctrl_en && !buf_empty && cur_ready;
	wire [1:0] lane = page_cnt[1:0];
	wire [1:0] lane_pos = byte_order_sel ? lane : ~lane;
	wire [31:0] next_wbuf = wbuf | ({24'h00_0000, ram_q} << {lane_pos, 3'b000});
	wire [3:0] next_wbe = wbe | (4'b0001 << lane_pos);
	wire page_end = page_cnt == page[cur_page].depth;
	wire flush = lane == 2'b11 || rd_pkt_end || page_end;
	wire [31:0] word_addr = page[cur_page].addr + {20'h0_0000, page_cnt[11:2], 2'b00};
	wire ack_end = rd_fsm == sbcb_pkg::RD_BUS && mem_ack && pend_end;
	wire [1:0] hw_done = {ack_end && cur_page, ack_end && !cur_page};
	wire ps_ev = rd_load && rd_pkt_start;
	wire [1:0] hw_ps = {ps_ev && cur_page, ps_ev && !cur_page};
	wire [1:0] hw_err = {ls_brk && cur_page, ls_brk && !cur_page};

	// Bytes still packed when the channel is disabled are dropped; only a started write finishes.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_fsm <= sbcb_pkg::RD_IDLE;
			wbuf <= `SBCB_RST_WORD;
			wbe <= 4'h0;
			page_cnt <= 12'h000;
			pend_end <= 1'b0;
			mem <= '0;
		end else begin
			unique case (rd_fsm)
				sbcb_pkg::RD_IDLE: begin
					if (rd_go) begin
						rd_fsm <= sbcb_pkg::RD_LOAD;
					end else if (!ctrl_en) begin
						page_cnt <= 12'h000;
						wbuf <= `SBCB_RST_WORD;
						wbe <= 4'h0;
					end
				end
				sbcb_pkg::RD_LOAD: begin
					wbuf <= next_wbuf;
					wbe <= next_wbe;
					page_cnt <= page_end ? 12'h000 : page_cnt + 12'h001;
					pend_end <= page_end;
					if (flush) begin
						mem <= '{req: 1'b1, addr: word_addr, data: next_wbuf, be: next_wbe};
						rd_fsm <= sbcb_pkg::RD_BUS;
					end else begin
						rd_fsm <= sbcb_pkg::RD_IDLE;
					end
				end
				sbcb_pkg::RD_BUS: begin
					if (mem_ack) begin
						mem.req <= 1'b0;
						wbuf <= `SBCB_RST_WORD;
						wbe <= 4'h0;
						rd_fsm <= sbcb_pkg::RD_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cur_page <= 1'b0;
		end else if (!ctrl_en) begin
			cur_page <= active_page_sel;
		end else if (ack_end) begin
			cur_page <= !cur_page;
		end
	end

	// ****************************************
	// Page descriptors
	// ****************************************
	for (genvar p = 0; p < 2; p++) begin : g_page
		assign wr_paddr[p] = reg_req.wr && ra == 8'(`SBCB_A_PADDR0 + p * `SBCB_A_PSTEP);
		assign wr_pctl[p] = reg_req.wr && ra == 8'(`SBCB_A_PCTL0 + p * `SBCB_A_PSTEP);
		assign page_rd[p] = (ra == 8'(`SBCB_A_PADDR0 + p * `SBCB_A_PSTEP)) ? page[p].addr :
			{12'h000, page[p].pstart, page[p].error, page[p].done, page[p].ready,
			4'h0, page[p].depth};

		// Hardware sets come last so an event beats a software clear in the same cycle.
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				page[p] <= '0;
			end else begin
				if (wr_paddr[p]) begin
					page[p].addr <= wd;
				end
				if (wr_pctl[p]) begin
					page[p].depth <= wd[11:0];
					page[p].ready <= wd[`SBCB_PCTL_RDY];
					page[p].done <= wd[`SBCB_PCTL_DONE];
					page[p].error <= wd[`SBCB_PCTL_ERR];
					page[p].pstart <= wd[`SBCB_PCTL_PS];
				end
				if (hw_done[p]) begin
					page[p].done <= 1'b1;
					page[p].ready <= 1'b0;
				end
				if (hw_err[p]) begin
					page[p].error <= 1'b1;
				end
				if (hw_ps[p]) begin
					page[p].pstart <= 1'b1;
				end
			end
		end
	end

	// ****************************************
	// Control and buffer registers
	// ****************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_en <= 1'b0;
			byte_order_sel <= 1'b0;
			active_page_sel <= 1'b0;
			base_offset <= '0;
			buffer_depth <= '0;
		end else begin
			if (wr_ctrl) begin
				ctrl_en <= wd[`SBCB_CTRL_EN];
				byte_order_sel <= wd[`SBCB_CTRL_BO];
				active_page_sel <= wd[`SBCB_CTRL_PG];
			end
			if (wr_bcfg) begin
				base_offset <= wd[AW-1:0];
				buffer_depth <= wd[`SBCB_HI_LSB +: AW];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_offset <= '0;
			wr_offset <= '0;
		end else if (wr_bptr) begin
			rd_offset <= wd[AW-1:0];
			wr_offset <= wd[`SBCB_HI_LSB +: AW];
		end else begin
			if (ram_we) begin
				wr_offset <= next_wr_offset;
			end
			if (rd_load) begin
				rd_offset <= next_rd_offset;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_packet_count <= 8'h00;
			wr_packet_count <= 8'h00;
			rd_state <= 5'h00;
			wr_state <= 5'h00;
		end else begin
			if (wr_bsts) begin
				rd_packet_count <= wd[7:0];
				wr_packet_count <= wd[`SBCB_BSTS_WRC +: 8];
				rd_state <= wd[`SBCB_BSTS_RDS +: 5];
				wr_state <= wd[`SBCB_BSTS_WRS +: 5];
			end
			if (wr_pkt_end) begin
				wr_packet_count <= wr_packet_count + 8'h01;
			end
			if (rd_pkt_end) begin
				rd_packet_count <= rd_packet_count + 8'h01;
			end
			if (ls_perr) begin
				rd_state[`SBCB_ST_PERR] <= 1'b1;
			end
			if (ls_brk) begin
				rd_state[`SBCB_ST_BRK] <= 1'b1;
			end
			if (wr_ovf) begin
				wr_state[`SBCB_ST_PERR] <= 1'b1;
			end
		end
	end

	// ****************************************
	// Interrupts and read-back
	// ****************************************
	wire [3:0] irq_ev = {ls_brk, ls_perr, wr_ovf, ack_end};
	wire [3:0] irq_clr = wr_iclr ? wd[3:0] : 4'h0;
	wire [31:0] rd_mux =
		(ra == `SBCB_A_CTRL) ? {29'h0000_0000, active_page_sel, byte_order_sel, ctrl_en} :
		(ra == `SBCB_A_BCFG) ? {{PAD{1'b0}}, buffer_depth, {PAD{1'b0}}, base_offset} :
		(ra == `SBCB_A_BPTR) ? {{PAD{1'b0}}, wr_offset, {PAD{1'b0}}, rd_offset} :
		(ra == `SBCB_A_BSTS) ? {3'h0, wr_state, 3'h0, rd_state, wr_packet_count,
			rd_packet_count} :
		(ra == `SBCB_A_PADDR0 || ra == `SBCB_A_PCTL0) ? page_rd[0] :
		(ra == 8'(`SBCB_A_PADDR0 + `SBCB_A_PSTEP) ||
			ra == 8'(`SBCB_A_PCTL0 + `SBCB_A_PSTEP)) ? page_rd[1] :
		(ra == `SBCB_A_ISTS) ? {28'h000_0000, irq_sts} :
		(ra == `SBCB_A_IEN) ? {28'h000_0000, irq_en} :
		`SBCB_RST_WORD;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_sts <= 4'h0;
			irq_en <= 4'h0;
			irq <= 1'b0;
			reg_rdata <= `SBCB_RST_WORD;
		end else begin
			irq_sts <= (irq_sts & ~irq_clr) | irq_ev;
			if (wr_ien) begin
				irq_en <= wd[3:0];
			end
			irq <= |(irq_sts & irq_en);
			reg_rdata <= reg_req.rd ? rd_mux : `SBCB_RST_WORD;
		end
	end

endmodule

`default_nettype wire

// file: rtl/sbcb_len_track.sv
`timescale 1ns/1ns
`default_nettype none

module sbcb_len_track (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Byte stream.
	input wire logic clr,
	input wire logic valid,
	input wire logic [7:0] data,
	// Packet boundaries.
	output wire logic pkt_start,
	output wire logic pkt_end
);

	logic [1:0] phase;
	logic [7:0] len_hi;
	logic [15:0] remain;
	wire [15:0] msg_length_field = {len_hi, data};

	assign pkt_start = valid && phase == 2'd0;
	assign pkt_end = valid && ((phase == 2'd1 && msg_length_field == 16'h0000) ||
		(phase == 2'd2 && remain == 16'h0001));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase <= 2'd0;
			len_hi <= 8'h00;
			remain <= 16'h0000;
		end else if (clr) begin
			phase <= 2'd0;
		end else if (valid) begin
			case (phase)
				2'd0: begin
					len_hi <= data;
					phase <= 2'd1;
				end
				2'd1: begin
					remain <= msg_length_field;
					phase <= (msg_length_field == 16'h0000) ? 2'd0 : 2'd2;
				end
				2'd2: begin
					remain <= remain - 16'h0001;
					if (remain == 16'h0001) begin
						phase <= 2'd0;
					end
				end
				default: begin
					phase <= 2'd0;
				end
			endcase
		end
	end

endmodule

`default_nettype wire

// file: rtl/sbcb_pkg.sv
package sbcb_pkg;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [31:0] wdata;
	} sbcb_reg_req_t;

	typedef struct packed {
		logic [31:0] addr;
		logic [11:0] depth;
		logic ready;
		logic done;
		logic error;
		logic pstart;
	} sbcb_page_t;

	typedef struct packed {
		logic req;
		logic [31:0] addr;
		logic [31:0] data;
		logic [3:0] be;
	} sbcb_mem_t;

	typedef enum logic [1:0] {RD_IDLE, RD_LOAD, RD_BUS} sbcb_rd_t;

endpackage

// file: rtl/sbcb_regs.svh
`ifndef SBCB_REGS_SVH
`define SBCB_REGS_SVH

// ****************************************
// Register byte addresses
// ****************************************
`define SBCB_A_CTRL 8'h00
`define SBCB_A_BCFG 8'h04
`define SBCB_A_BPTR 8'h08
`define SBCB_A_BSTS 8'h0C
`define SBCB_A_PADDR0 8'h10
`define SBCB_A_PCTL0 8'h14
`define SBCB_A_PSTEP 8'h08
`define SBCB_A_ISTS 8'h20
`define SBCB_A_ICLR 8'h24
`define SBCB_A_IEN 8'h28

// ****************************************
// Field positions
// ****************************************
`define SBCB_CTRL_EN 0
`define SBCB_CTRL_BO 1
`define SBCB_CTRL_PG 2
`define SBCB_HI_LSB 16
`define SBCB_BSTS_WRC 8
`define SBCB_BSTS_RDS 16
`define SBCB_BSTS_WRS 24
`define SBCB_PCTL_RDY 16
`define SBCB_PCTL_DONE 17
`define SBCB_PCTL_ERR 18
`define SBCB_PCTL_PS 19
`define SBCB_ST_PERR 2
`define SBCB_ST_BRK 4
`define SBCB_IRQ_DONE 0
`define SBCB_IRQ_OVF 1
`define SBCB_IRQ_PERR 2
`define SBCB_IRQ_BRK 3

// ****************************************
// Reset values
// ****************************************
`define SBCB_RST_WORD 32'h0000_0000

`endif

// file: rtl/sbcb_sync.sv
`timescale 1ns/1ns
`default_nettype none

module sbcb_sync #(
	parameter int W = 1
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Raw and filtered levels.
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;

	// A bit only moves once the second and third stages agree, which also drops single glitches.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			q <= '0;
		end else begin
			s1 <= d;
			s2 <= s1;
			s3 <= s2;
			q <= (s2 & s3) | (q & (s2 ^ s3));
		end
	end

endmodule

`default_nettype wire

// file: verification/sbcb_channel_checker.sv
`timescale 1ns/1ns
`default_nettype none
`include "sbcb_regs.svh"

module sbcb_channel_checker #(
	parameter int RAM_BYTES = 16384
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Register port.
	input wire sbcb_pkg::sbcb_reg_req_t reg_req,
	input wire logic [31:0] reg_rdata,
	// Serial link pins.
	input wire logic link_clk,
	input wire logic link_frame,
	input wire logic link_data,
	input wire logic far_end_abort,
	input wire logic far_end_protocol_fault,
	// System memory write master.
	input wire sbcb_pkg::sbcb_mem_t mem,
	input wire logic mem_ack,
	// Interrupt.
	input wire logic irq
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence ctrl_wr_rd;
		reg_req.wr && reg_req.addr == `SBCB_A_CTRL ##1 reg_req.rd && reg_req.addr == `SBCB_A_CTRL;
	endsequence

	a_rdata_idle: assert property (!$past(reg_req.rd) |-> reg_rdata == 32'h0000_0000)
		else $error("read data not zero outside its answer cycle");
	a_unmapped_zero: assert property (reg_req.rd && reg_req.addr inside {`SBCB_A_ICLR, 8'h2C, 8'h30}
		|=> reg_rdata == 32'h0000_0000)
		else $error("write-only or unmapped place read non-zero");
	a_ctrl_rsvd: assert property (reg_req.rd && reg_req.addr == `SBCB_A_CTRL
		|=> reg_rdata[31:3] == 29'h0)
		else $error("control reserved bits read non-zero");
	a_ctrl_rb: assert property (ctrl_wr_rd |=> reg_rdata[2:0] == $past(reg_req.wdata[2:0], 2))
		else $error("control bits did not read back as written");
	a_req_hold: assert property (mem.req && !mem_ack |=> mem.req && $stable(mem))
		else $error("memory request changed before acknowledge");
	a_req_drop: assert property (mem.req && mem_ack |=> !mem.req)
		else $error("memory request stayed up after acknowledge");
	a_be_lanes: assert property (mem.req |-> mem.be != 4'h0 && mem.addr[1:0] == 2'b00)
		else $error("memory write without lanes or off word");
	a_irq_mask: assert property (reg_req.wr && reg_req.addr == `SBCB_A_IEN
		&& reg_req.wdata[3:0] == 4'h0 |-> ##2 !irq[*3])
		else $error("interrupt stayed up with all sources masked");

	c_mem_write: cover property (mem.req && mem_ack);
	c_irq: cover property ($rose(irq));
	c_read: cover property (reg_req.rd ##1 reg_rdata != 32'h0000_0000);
endmodule

bind sbcb_channel sbcb_channel_checker #(.RAM_BYTES(RAM_BYTES)) u_checker (.clk(clk),
	.rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata), .link_clk(link_clk),
	.link_frame(link_frame), .link_data(link_data), .far_end_abort(far_end_abort),
	.far_end_protocol_fault(far_end_protocol_fault), .mem(mem), .mem_ack(mem_ack), .irq(irq));

`default_nettype wire

// file: verification/sbcb_mem_model.sv
`timescale 1ns/1ns
`default_nettype none

module sbcb_mem_model (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Write master side.
	input wire sbcb_pkg::sbcb_mem_t mem,
	input wire logic [3:0] lat,
	output logic mem_ack
);
	logic [31:0] wa[$];
	logic [31:0] wd[$];
	logic [3:0] wb[$];
	logic [3:0] waited;

	// A write is taken only at the edge where the ack is seen, as the master does.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_ack <= 1'b0;
			waited <= 4'h0;
		end else if (mem_ack) begin
			mem_ack <= 1'b0;
			waited <= 4'h0;
			if (mem.req) begin
				wa.push_back(mem.addr);
				wd.push_back(mem.data);
				wb.push_back(mem.be);
			end
		end else if (mem.req && waited >= lat) begin
			mem_ack <= 1'b1;
		end else if (mem.req) begin
			waited <= waited + 4'h1;
		end
	end
endmodule

`default_nettype wire

// file: verification/serial_bus_channel_buffer_dma_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "sbcb_regs.svh"

module serial_bus_channel_buffer_dma_tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	sbcb_pkg::sbcb_reg_req_t reg_req = '0;
	logic [31:0] reg_rdata;
	logic link_clk = 1'b0;
	logic link_frame = 1'b0;
	logic link_data = 1'b0;
	logic far_end_abort = 1'b0;
	logic far_end_protocol_fault = 1'b0;
	sbcb_pkg::sbcb_mem_t mem;
	logic mem_ack;
	logic irq;
	logic [3:0] lat = 4'h0;
	int fails = 0;
	int checked = 0;
	int total = 0;
	int np = 0;
	int cur;
	int cnt;
	int pl[2];
	logic [31:0] pa[2] = '{32'h0000_1000, 32'h0000_2000};
	logic [31:0] q;
	logic [31:0] acc_w;
	logic [3:0] acc_b;
	logic bo;
	logic [13:0] base;
	logic xon = 1'b0;
	logic [31:0] ex_a[$];
	logic [31:0] ex_d[$];
	logic [3:0] ex_b[$];
	logic [7:0] ra[7] = '{`SBCB_A_CTRL, `SBCB_A_BCFG, `SBCB_A_BPTR, `SBCB_A_BSTS,
		`SBCB_A_ISTS, `SBCB_A_IEN, 8'h30};

	always #10 clk = ~clk;

	sbcb_channel #(.RAM_BYTES(256)) DUT (.clk(clk), .rst_n(rst_n), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .link_clk(link_clk), .link_frame(link_frame),
		.link_data(link_data), .far_end_abort(far_end_abort),
		.far_end_protocol_fault(far_end_protocol_fault), .mem(mem), .mem_ack(mem_ack), .irq(irq));
	sbcb_mem_model u_mem (.clk(clk), .rst_n(rst_n), .mem(mem), .lat(lat), .mem_ack(mem_ack));

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Both offsets wrap on the 32-byte buffer the bench programs.
	function automatic logic [31:0] exp_ptr(input int n);
		return {2'b0, 14'(n % 32), 2'b0, 14'(n % 32)};
	endfunction

	task automatic conclude();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Every write is read straight back, so each access starts with one idle edge.
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		if (w) begin
			@(posedge clk);
			reg_req <= '{1'b1, 1'b0, a, d};
		end
		@(posedge clk);
		reg_req <= '{1'b0, 1'b1, a, d};
		@(posedge clk);
		reg_req <= '0;
		#1 q = reg_rdata;
	endtask

	task automatic push(input logic [7:0] b, input logic last);
		int ln;
		ln = cnt % 4;
		if (!xon) return;
		if (bo) begin
			acc_w[8*ln +: 8] = b;
			acc_b[ln] = 1'b1;
		end else begin
			acc_w[24-8*ln +: 8] = b;
			acc_b[3-ln] = 1'b1;
		end
		if (ln == 3 || last || cnt == pl[cur] - 1) begin
			ex_a.push_back(pa[cur] + 32'(cnt & ~3));
			ex_d.push_back(acc_w);
			ex_b.push_back(acc_b);
			acc_b = 4'h0;
		end
		cnt++;
		if (cnt == pl[cur]) begin
			cnt = 0;
			cur = 1 - cur;
		end
	endtask

	// The link clock runs only inside frames, four system clocks per half period.
	task automatic send_pkt(input int n);
		logic [7:0] b;
		@(posedge clk);
		link_frame <= 1'b1;
		for (int i = 0; i < n + 2; i++) begin
			b = (i == 0) ? n[15:8] : (i == 1) ? n[7:0] : 8'($urandom);
			push(b, i == n + 1);
			for (int k = 7; k >= 0; k--) begin
				link_data <= b[k];
				repeat (4) @(posedge clk);
				link_clk <= 1'b1;
				repeat (4) @(posedge clk);
				link_clk <= 1'b0;
			end
		end
		repeat (4) @(posedge clk);
		link_frame <= 1'b0;
		link_data <= ~link_data;
		repeat (8) @(posedge clk);
	endtask

	task automatic cmp_mem();
		logic [31:0] m;
		for (int i = 0; u_mem.wa.size() < ex_a.size(); i++) begin
			@(posedge clk);
			if (i > 4000) begin
				check("mem_wait", 32'h0, 32'h1);
				conclude();
			end
		end
		repeat (20) @(posedge clk);
		check("mem_count", 32'(u_mem.wa.size()), 32'(ex_a.size()));
		foreach (ex_a[i]) begin
			m = {{8{ex_b[i][3]}}, {8{ex_b[i][2]}}, {8{ex_b[i][1]}}, {8{ex_b[i][0]}}};
			check("mem_addr", u_mem.wa[i], ex_a[i]);
			check("mem_be", {28'h0, u_mem.wb[i]}, {28'h0, ex_b[i]});
			check("mem_data", u_mem.wd[i] & m, ex_d[i] & m);
		end
		ex_a.delete();
		ex_d.delete();
		ex_b.delete();
		u_mem.wa.delete();
		u_mem.wd.delete();
		u_mem.wb.delete();
	endtask

	task automatic run(input logic sel, input logic b_o, input int l0);
		int ln[4];
		int t;
		t = 0;
		for (int i = 0; i < 4; i++) begin
			ln[i] = (i == 0 && !sel) ? 0 : 3 + $urandom_range(9);
			t += ln[i] + 2;
		end
		pl[sel] = l0;
		pl[!sel] = t - l0;
		cur = sel;
		cnt = 0;
		bo = b_o;
		acc_b = 4'h0;
		acc(1, `SBCB_A_CTRL, {29'h0, sel, b_o, 1'b0});
		for (int p = 0; p < 2; p++) begin
			acc(1, `SBCB_A_PADDR0 + 8'(p * `SBCB_A_PSTEP), pa[p]);
			acc(1, `SBCB_A_PCTL0 + 8'(p * `SBCB_A_PSTEP),
				32'h0001_0000 | (32'(p == sel) << 19) | 32'(pl[p] - 1));
		end
		acc(1, `SBCB_A_CTRL, {29'h0, sel, b_o, 1'b1});
		xon = 1'b1;
		foreach (ln[i]) send_pkt(ln[i]);
		cmp_mem();
		total += t;
		np += 4;
		acc(0, `SBCB_A_BPTR, 0);
		check("bptr", q, exp_ptr(total));
		acc(0, `SBCB_A_BSTS, 0);
		check("bsts", q, {16'h0, 8'(np), 8'(np)});
		acc(0, `SBCB_A_PCTL0 + 8'(sel * `SBCB_A_PSTEP), 0);
		check("page_flags", {28'h0, q[19:16]}, 32'hA);
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		void'($urandom(74));
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		foreach (ra[i]) begin
			acc(0, ra[i], 0);
			check("reset_value", q, `SBCB_RST_WORD);
		end
		base = 14'($urandom_range(224));
		acc(1, `SBCB_A_BCFG, {16'h001F, 2'b0, base});
		check("bcfg", q, {16'h001F, 2'b0, base});
		acc(1, `SBCB_A_BPTR, 0);
		acc(1, `SBCB_A_IEN, 32'h0000_000F);
		check("ien", q, 32'h0000_000F);
		$display("test registers done");
		send_pkt(1);
		acc(0, `SBCB_A_BPTR, 0);
		check("bptr_disabled", q, 32'h0);
		$display("test disabled done");
		run(1'b0, 1'b1, 12);
		acc(0, `SBCB_A_ISTS, 0);
		check("ists_done", q, 32'h1);
		check("irq_on", {31'h0, irq}, 32'h1);
		acc(1, `SBCB_A_IEN, 0);
		check("irq_masked", {31'h0, irq}, 32'h0);
		acc(1, `SBCB_A_IEN, 32'h0000_000F);
		acc(1, `SBCB_A_ICLR, 32'h0000_000F);
		acc(0, `SBCB_A_ISTS, 0);
		check("ists_clear", q, 32'h0);
		check("irq_off", {31'h0, irq}, 32'h0);
		$display("test little ping done");
		lat = 4'h6;
		run(1'b1, 1'b0, 8);
		$display("test big pong done");
		xon = 1'b0;
		repeat (4) send_pkt(6);
		acc(0, `SBCB_A_BPTR, 0);
		check("bptr_full", q, exp_ptr(total));
		acc(0, `SBCB_A_BSTS, 0);
		check("bsts_full", q, {16'h0, 8'(np + 4), 8'(np)});
		send_pkt(6);
		acc(0, `SBCB_A_BSTS, 0);
		check("wr_state", {27'h0, q[28:24]}, 32'h4);
		$display("test overflow done");
		for (int f = 0; f < 2; f++) begin
			@(posedge clk);
			{far_end_abort, far_end_protocol_fault} <= f ? 2'b10 : 2'b01;
			repeat (10) @(posedge clk);
			{far_end_abort, far_end_protocol_fault} <= 2'b00;
			acc(0, `SBCB_A_BSTS, 0);
			check("rd_state", {27'h0, q[20:16]}, f ? 32'h14 : 32'h4);
		end
		acc(0, `SBCB_A_PCTL0 + `SBCB_A_PSTEP, 0);
		check("page_error", {31'h0, q[18]}, 32'h1);
		acc(0, `SBCB_A_ISTS, 0);
		check("ists_all", q, 32'hF);
		acc(1, `SBCB_A_ICLR, 32'h0000_000F);
		acc(0, `SBCB_A_ISTS, 0);
		check("ists_end", q, 32'h0);
		$display("test faults done");
		conclude();
	end
endmodule

`default_nettype wire
